// ---- ddr_burst_sram.sv ----
// double-data-rate burst sram core with strap-selected read latency
`include "ddr_sram_map.svh"
`default_nettype none

module ddr_burst_sram
    import ddr_sram_pkg::*;
#(
    parameter int AW     = 10,
    parameter int DW     = 18,
    parameter int BYTE_W = 9
) (
    input  wire logic                MCLK,
    input  wire logic                RESET,
    input  wire logic                K_RISE,
    input  wire logic                KN_RISE,
    input  wire logic                C_RISE,
    input  wire logic                CN_RISE,
    input  wire logic                C_HIGH,
    input  wire logic                CN_HIGH,
    input  wire logic                PLL_DISABLE_N,
    input  wire logic                LOAD_N,
    input  wire logic                RW,
    input  wire logic [DW/BYTE_W-1:0] BYTE_WRITE_SELECT_N,
    input  wire logic [AW-1:0]       ADDR,
    input  wire logic [DW-1:0]       D,
    output logic      [DW-1:0]       Q,
    output logic                     Q_OE,
    output logic                     LEGACY_MODE,
    input  wire logic                HSEL,
    input  wire logic [31:0]         HADDR,
    input  wire logic [1:0]          HTRANS,
    input  wire logic                HWRITE,
    input  wire logic [2:0]          HSIZE,
    input  wire logic [31:0]         HWDATA,
    input  wire logic                HREADY,
    output logic      [31:0]         HRDATA,
    output logic                     HREADYOUT,
    output logic                     HRESP
);

    localparam int BPW = DW / BYTE_W;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic              strap_done_q, legacy_q, single_q;
    logic [31:0]       ctrl_q, rd_cnt_q, wr_cnt_q, hrdata_q;
    logic              hready_q, hresp_q;
    logic              dp_write_q;
    logic [`SRAM_DEC_W-1:0] dp_addr_q;
    logic              rs1_valid_q, ws1_valid_q;
    logic [AW-1:0]     rs1_addr_q, ws1_addr_q, rd_addr_q, wr_addr_q;
    rd_state_t         rd_state_q;
    wr_state_t         wr_state_q;
    logic [DW-1:0]     wd0_q, q_q;
    logic [BPW-1:0]    be0_q;
    logic              q_oe_q;
    logic              accept, load_rd, load_wr, out_pos, out_neg;
    logic              first_edge, second_edge, move, early0, launch0, launch1;
    logic              commit, ahb_take;
    logic [AW-1:0]     launch_addr;
    logic [2*DW-1:0]   row_rd, row_wr;
    logic [2*BPW-1:0]  row_be;
    logic [31:0]       status;

    // ----------------------------------------------------------------
    // strap capture and mode selection
    // ----------------------------------------------------------------
    // straps caught once, on the first edge after reset release
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            strap_done_q <= 1'b0;
            legacy_q     <= 1'b0;
            single_q     <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            legacy_q     <= !PLL_DISABLE_N;
            single_q     <= C_HIGH && CN_HIGH;
        end
    end

    // output clock pair, or the input pair in single clock mode
    assign out_pos = single_q ? K_RISE : C_RISE;
    assign out_neg = single_q ? KN_RISE : CN_RISE;

    // ----------------------------------------------------------------
    // command capture
    // ----------------------------------------------------------------
    assign accept  = K_RISE && strap_done_q && ctrl_q[`SRAM_CTRL_EN_BIT] && !LOAD_N;
    assign load_rd = accept && RW;
    assign load_wr = accept && !RW;

    // address and type registered on the positive input clock only
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rs1_valid_q <= 1'b0;
            ws1_valid_q <= 1'b0;
            rs1_addr_q  <= '0;
            ws1_addr_q  <= '0;
        end else if (K_RISE) begin
            rs1_valid_q <= load_rd;
            ws1_valid_q <= load_wr;
            rs1_addr_q  <= ADDR;
            ws1_addr_q  <= ADDR;
        end
    end

    // ----------------------------------------------------------------
    // read pipeline
    // ----------------------------------------------------------------
    // normal mode: word0 on output negative edge after next k rise
    assign first_edge  = legacy_q ? out_pos : out_neg;
    assign second_edge = legacy_q ? out_neg : out_pos;
    assign move        = K_RISE && rs1_valid_q;
    assign early0      = move && legacy_q && out_pos;
    assign launch0     = early0 || (rd_state_q == RD_WORD0 && first_edge);
    assign launch1     = rd_state_q == RD_WORD1 && second_edge;
    assign launch_addr = early0 ? rs1_addr_q :
                         (launch1 ? (rd_addr_q ^ {{(AW-1){1'b0}}, 1'b1}) : rd_addr_q);

    // burst state advances one word per output edge
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rd_state_q <= RD_IDLE;
            rd_addr_q  <= '0;
        end else if (move) begin
            rd_addr_q  <= rs1_addr_q;
            rd_state_q <= early0 ? RD_WORD1 : RD_WORD0;
        end else if (launch0) begin
            rd_state_q <= RD_WORD1;
        end else if (launch1) begin
            rd_state_q <= RD_IDLE;
        end
    end

    // output register and drive enable
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            q_q    <= '0;
            q_oe_q <= 1'b0;
        end else if (launch0 || launch1) begin
            q_q    <= launch_addr[0] ? row_rd[DW +: DW] : row_rd[0 +: DW];
            q_oe_q <= 1'b1;
        end else if (out_pos && rd_state_q == RD_IDLE && !move) begin
            q_oe_q <= 1'b0;  // release bus once reads are done
        end
    end

    // ----------------------------------------------------------------
    // write pipeline
    // ----------------------------------------------------------------
    assign commit = KN_RISE && wr_state_q == WR_WORD1;

    // word0 on the k rise after the command, word1 on the k-bar rise
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            wr_state_q <= WR_IDLE;
            wr_addr_q  <= '0;
            wd0_q      <= '0;
            be0_q      <= '0;
        end else if (K_RISE && ws1_valid_q) begin
            wr_state_q <= WR_WORD1;
            wr_addr_q  <= ws1_addr_q;
            wd0_q      <= D;
            be0_q      <= ~BYTE_WRITE_SELECT_N;
        end else if (commit) begin
            wr_state_q <= WR_IDLE;
        end
    end

    // place word0 at the burst start half, word1 in the other half
    assign row_wr = wr_addr_q[0] ? {wd0_q, D} : {D, wd0_q};
    assign row_be = wr_addr_q[0] ? {be0_q, ~BYTE_WRITE_SELECT_N}
                                 : {~BYTE_WRITE_SELECT_N, be0_q};

    burst_mem_array #(
        .ROW_AW     (AW - 1),
        .BYTE_W     (BYTE_W),
        .LANES      (2 * BPW)
    ) u_mem (
        .clk        (MCLK),
        .wr_en      (commit),
        .wr_row     (wr_addr_q[AW-1:1]),
        .wr_lane_en (row_be),
        .wr_data    (row_wr),
        .rd_row     (launch_addr[AW-1:1]),
        .rd_data    (row_rd)
    );

    // ----------------------------------------------------------------
    // activity counters
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rd_cnt_q <= `SRAM_CNT_RESET;
            wr_cnt_q <= `SRAM_CNT_RESET;
        end else begin
            if (move) begin
                rd_cnt_q <= rd_cnt_q + `SRAM_CNT_ONE;
            end
            if (commit) begin
                wr_cnt_q <= wr_cnt_q + `SRAM_CNT_ONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------------------------------
    assign ahb_take = HSEL && HTRANS[`AHB_TRANS_ACTIVE] && HREADY;

    always_comb begin
        status = '0;
        status[`SRAM_STAT_LEGACY]   = legacy_q;
        status[`SRAM_STAT_SINGLE]   = single_q;
        status[`SRAM_STAT_RDBUSY]   = rd_state_q != RD_IDLE || rs1_valid_q;
        status[`SRAM_STAT_WRBUSY]   = wr_state_q != WR_IDLE || ws1_valid_q;
        status[`SRAM_STAT_STRAPPED] = strap_done_q;
    end

    // address phase latch; read data prepared for the data phase
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            dp_write_q <= 1'b0;
            dp_addr_q  <= '0;
            hrdata_q   <= '0;
        end else begin
            dp_write_q <= ahb_take && HWRITE;
            dp_addr_q  <= HADDR[`SRAM_DEC_W-1:0];
            if (ahb_take && !HWRITE) begin
                unique case (HADDR[`SRAM_DEC_W-1:0])
                    `SRAM_REG_STATUS: hrdata_q <= status;
                    `SRAM_REG_CTRL:   hrdata_q <= ctrl_q;
                    `SRAM_REG_RDCNT:  hrdata_q <= rd_cnt_q;
                    `SRAM_REG_WRCNT:  hrdata_q <= wr_cnt_q;
                    default:          hrdata_q <= '0;  // unmapped reads zero
                endcase
            end
        end
    end

    // control register written in the data phase
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ctrl_q <= `SRAM_CTRL_RESET;
        end else if (dp_write_q && dp_addr_q == `SRAM_REG_CTRL) begin
            ctrl_q <= {31'h0000_0000, HWDATA[`SRAM_CTRL_EN_BIT]};
        end
    end

    // handshake flops: always ready, always okay
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            hready_q <= 1'b1;
            hresp_q  <= `AHB_RESP_OKAY;
        end else begin
            hready_q <= 1'b1;
            hresp_q  <= `AHB_RESP_OKAY;
        end
    end

    assign Q           = q_q;
    assign Q_OE        = q_oe_q;
    assign LEGACY_MODE = legacy_q;
    assign HRDATA      = hrdata_q;
    assign HREADYOUT   = hready_q;
    assign HRESP       = hresp_q;

endmodule

`default_nettype wire

// ---- ddr_sram_map.svh ----
// address map, field positions and reset values of the burst sram block
`ifndef DDR_SRAM_MAP_SVH
`define DDR_SRAM_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets (low address byte)
// ----------------------------------------------------------------
`define SRAM_REG_STATUS     8'h00
`define SRAM_REG_CTRL       8'h04
`define SRAM_REG_RDCNT      8'h08
`define SRAM_REG_WRCNT      8'h0C
`define SRAM_DEC_W          8

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SRAM_CTRL_RESET     32'h0000_0001
`define SRAM_CTRL_EN_BIT    0
`define SRAM_STAT_LEGACY    0
`define SRAM_STAT_SINGLE    1
`define SRAM_STAT_RDBUSY    2
`define SRAM_STAT_WRBUSY    3
`define SRAM_STAT_STRAPPED  4
`define SRAM_CNT_RESET      32'h0000_0000
`define SRAM_CNT_ONE        32'h0000_0001

// ----------------------------------------------------------------
// ahb-lite encodings
// ----------------------------------------------------------------
`define AHB_TRANS_ACTIVE    1
`define AHB_RESP_OKAY       1'b0

`endif

// ---- ddr_sram_pkg.sv ----
// types shared by the burst sram block
`default_nettype none

package ddr_sram_pkg;

    // read launch pipeline: which burst word goes out next
    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,
        RD_WORD0 = 2'b01,
        RD_WORD1 = 2'b10
    } rd_state_t;

    // write capture pipeline: waiting for the second data word
    typedef enum logic [0:0] {
        WR_IDLE  = 1'b0,
        WR_WORD1 = 1'b1
    } wr_state_t;

endpackage

`default_nettype wire

// ---- burst_mem_array.sv ----
// storage array: one row holds a two-word burst, written per byte lane
`default_nettype none

module burst_mem_array #(
    parameter int ROW_AW = 9,
    parameter int BYTE_W = 9,
    parameter int LANES  = 4
) (
    input  wire logic                      clk,
    input  wire logic                      wr_en,
    input  wire logic [ROW_AW-1:0]         wr_row,
    input  wire logic [LANES-1:0]          wr_lane_en,
    input  wire logic [LANES*BYTE_W-1:0]   wr_data,
    input  wire logic [ROW_AW-1:0]         rd_row,
    output logic      [LANES*BYTE_W-1:0]   rd_data
);

    // ----------------------------------------------------------------
    // one array per byte lane, so lanes write independently
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            logic [BYTE_W-1:0] lane_mem [2**ROW_AW];

            // masked lanes keep their stored byte
            always_ff @(posedge clk) begin
                if (wr_en && wr_lane_en[g]) begin
                    lane_mem[wr_row] <= wr_data[g*BYTE_W +: BYTE_W];
                end
            end

            assign rd_data[g*BYTE_W +: BYTE_W] = lane_mem[rd_row];
        end
    endgenerate

endmodule

`default_nettype wire

// ---- ddr_sram_monitor.sv ----
// port checker for the burst sram core
`default_nettype none

module ddr_sram_monitor #(
    parameter int DW = 18
) (
    input wire logic          MCLK,
    input wire logic          RESET,
    input wire logic          K_RISE,
    input wire logic          KN_RISE,
    input wire logic          C_RISE,
    input wire logic          CN_RISE,
    input wire logic          C_HIGH,
    input wire logic          CN_HIGH,
    input wire logic          PLL_DISABLE_N,
    input wire logic          LOAD_N,
    input wire logic          RW,
    input wire logic [DW-1:0] Q,
    input wire logic          Q_OE,
    input wire logic          LEGACY_MODE
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // read loads and timing checks
    // -------------------------------------------------------------
    logic load_rd, out_pos, out_neg;

    // a read request as taken on a k rise
    assign load_rd = K_RISE && !LOAD_N && RW;

    // output clock rises, or the input pair when both output clocks sit high
    assign out_pos = (C_HIGH && CN_HIGH) ? K_RISE : C_RISE;
    assign out_neg = (C_HIGH && CN_HIGH) ? KN_RISE : CN_RISE;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    strap_latch_a: assert property (
        $fell(RESET) |=> LEGACY_MODE == !$past(PLL_DISABLE_N))
        else $error("legacy mode differs from the latched strap");
    mode_static_a: assert property (
        !$past(RESET, 2) && !$past(RESET) |-> $stable(LEGACY_MODE))
        else $error("legacy mode moved after latching");
    lat_normal_a: assert property (
        $rose(Q_OE) && !LEGACY_MODE |-> $past(load_rd, 4))
        else $error("normal mode read latency wrong");
    lat_legacy_a: assert property (
        $rose(Q_OE) && LEGACY_MODE |-> $past(load_rd, 3))
        else $error("legacy mode read latency wrong");
    q_launch_a: assert property (
        $changed(Q) |-> Q_OE && $past(out_pos || out_neg))
        else $error("read data moved without an output clock rise");
    oe_release_a: assert property (
        $fell(Q_OE) |-> $past(out_pos))
        else $error("output enable dropped off the positive output clock");
    oe_burst_a: assert property (
        $rose(Q_OE) |-> ##1 Q_OE)
        else $error("output enable too short for a burst");
    reset_vals_a: assert property (
        $fell(RESET) |-> !LEGACY_MODE && !Q_OE && Q == '0)
        else $error("outputs not at reset values after release");
endmodule

`default_nettype wire

// ---- ddr_ctrl_model.sv ----
// controller side model: input and output clock rise pulses
`default_nettype none

module ddr_ctrl_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic single,
    output logic      k_rise,
    output logic      kn_rise,
    output logic      c_rise,
    output logic      cn_rise,
    output logic      c_high,
    output logic      cn_high
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // clock pair generation
    // -------------------------------------------------------------
    logic phase_q;

    // k pair at half the mclk rate, far below the legacy limit
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // output clocks follow k with zero skew; tied high they never rise
    assign k_rise  = phase_q;
    assign kn_rise = ~phase_q;
    assign c_rise  = phase_q && !single;
    assign cn_rise = !phase_q && !single;
    assign c_high  = single;
    assign cn_high = single;
endmodule

`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the burst sram core
`include "ddr_sram_map.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // signals, design and controller model
    // -------------------------------------------------------------
    logic        MCLK, RESET, PLL_DISABLE_N, LOAD_N, RW, HSEL, HWRITE;
    logic        K_RISE, KN_RISE, C_RISE, CN_RISE, C_HIGH, CN_HIGH, single_sel;
    logic        Q_OE, LEGACY_MODE, HREADYOUT, HRESP;
    logic [1:0]  BYTE_WRITE_SELECT_N, HTRANS;
    logic [9:0]  ADDR;
    logic [17:0] D, Q, w0, w1;
    logic [31:0] HADDR, HWDATA, HRDATA, r;
    int          n_mismatch, cmp_count, lat;

    ddr_burst_sram uut (.MCLK(MCLK), .RESET(RESET), .K_RISE(K_RISE), .KN_RISE(KN_RISE),
        .C_RISE(C_RISE), .CN_RISE(CN_RISE), .C_HIGH(C_HIGH), .CN_HIGH(CN_HIGH),
        .PLL_DISABLE_N(PLL_DISABLE_N), .LOAD_N(LOAD_N), .RW(RW),
        .BYTE_WRITE_SELECT_N(BYTE_WRITE_SELECT_N), .ADDR(ADDR), .D(D), .Q(Q),
        .Q_OE(Q_OE), .LEGACY_MODE(LEGACY_MODE), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

    ddr_ctrl_model ctl (.clk(MCLK), .rst(RESET), .single(single_sel),
        .k_rise(K_RISE), .kn_rise(KN_RISE),
        .c_rise(C_RISE), .cn_rise(CN_RISE), .c_high(C_HIGH), .cn_high(CN_HIGH));

    // 100 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // waits for hready at a rising edge, taking read data at the falling edge before it
    task automatic bus_wait(output logic [31:0] rd);
        logic rdy;
        for (int n = 0; n < 16; n++) begin
            @(negedge MCLK);
            rdy = HREADYOUT;
            rd = HRDATA;
            @(posedge MCLK);
            if (rdy === 1'b1) return;
        end
        n_mismatch++;
        conclude;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic [31:0] dummy;
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= wr;
        bus_wait(dummy);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        bus_wait(rd);
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask

    // returns just after the edge before a k rise
    task automatic k_align;
        for (int n = 0; n < 4; n++) begin
            @(negedge MCLK);
            if (K_RISE === 1'b0) begin
                @(posedge MCLK);
                return;
            end
        end
        n_mismatch++;
        conclude;
    endtask

    // load held over the kn rise too, with a stray address there
    task automatic sram_ld(input logic rw_sel, input logic [9:0] a);
        k_align;
        LOAD_N <= 1'b0;
        RW <= rw_sel;
        ADDR <= a;
        @(posedge MCLK);
        ADDR <= ~a;
        @(posedge MCLK);
        LOAD_N <= 1'b1;
    endtask

    task automatic sram_wr(input logic [9:0] a, input logic [17:0] d0, d1,
                           input logic [1:0] lanes_n);
        sram_ld(1'b0, a);
        D <= d0;
        BYTE_WRITE_SELECT_N <= lanes_n;
        @(posedge MCLK);
        D <= d1;
        @(posedge MCLK);
        D <= ~d1;
        BYTE_WRITE_SELECT_N <= 2'h3;
    endtask

    task automatic sram_rd(input logic [9:0] a, input logic [17:0] e0, e1, input int lat);
        sram_ld(1'b1, a);
        repeat (lat - 1) @(posedge MCLK);
        @(negedge MCLK);
        check(Q, e0);
        check(Q_OE, 1'b1);
        @(negedge MCLK);
        check(Q, e1);
        @(posedge MCLK);
    endtask

    // -------------------------------------------------------------
    // main sequence: normal strap, grounded strap, then single clock
    // -------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        LOAD_N <= 1'b1;
        RW <= 1'b1;
        ADDR <= 10'h000;
        D <= 18'h00000;
        BYTE_WRITE_SELECT_N <= 2'h3;
        HSEL <= 1'b0;
        HADDR <= 32'h0;
        HTRANS <= 2'h0;
        HWRITE <= 1'b0;
        HWDATA <= 32'h0;
        for (int m = 0; m < 3; m++) begin
            w0 = 18'h2A5C3 + 18'(m * 32'h0000_1111);
            w1 = 18'h15A3C + 18'(m * 32'h0000_1111);
            lat = (m == 1) ? 2 : 3;
            RESET <= 1'b1;
            PLL_DISABLE_N <= (m != 1);
            single_sel <= (m == 2);
            repeat (16) @(posedge MCLK);
            RESET <= 1'b0;
            repeat (2) @(posedge MCLK);
            PLL_DISABLE_N <= (m == 1);
            r = (32'h1 << `SRAM_STAT_STRAPPED) | (32'(m == 1) << `SRAM_STAT_LEGACY)
                | (32'(m == 2) << `SRAM_STAT_SINGLE);
            reg_chk(`SRAM_REG_STATUS, r);
            check(LEGACY_MODE, 32'(m == 1));
            reg_chk(`SRAM_REG_CTRL, `SRAM_CTRL_RESET);
            reg_chk(`SRAM_REG_RDCNT, `SRAM_CNT_RESET);
            reg_chk(8'h40, 32'h0);
            sram_wr(10'h014, w0, w1, 2'h0);
            sram_rd(10'h015, w1, w0, lat);
            sram_wr(10'h014, 18'h3FFFF, 18'h00000, 2'h2);
            sram_rd(10'h014, {w0[17:9], 9'h1FF}, {w1[17:9], 9'h000}, lat);
            reg_chk(`SRAM_REG_RDCNT, 32'h2);
            reg_chk(`SRAM_REG_WRCNT, 32'h2);
            ahb(1'b1, `SRAM_REG_CTRL, 32'h0, r);
            sram_ld(1'b1, 10'h014);
            repeat (2) @(posedge MCLK);
            @(negedge MCLK);
            check(Q_OE, 1'b0);
            @(posedge MCLK);
            reg_chk(`SRAM_REG_RDCNT, 32'h2);
            check(HRESP, `AHB_RESP_OKAY);
        end
        conclude;
    end
endmodule

bind ddr_burst_sram ddr_sram_monitor #(.DW(DW)) chk (.MCLK(MCLK), .RESET(RESET),
    .K_RISE(K_RISE), .KN_RISE(KN_RISE), .C_RISE(C_RISE), .CN_RISE(CN_RISE),
    .C_HIGH(C_HIGH), .CN_HIGH(CN_HIGH), .PLL_DISABLE_N(PLL_DISABLE_N),
    .LOAD_N(LOAD_N), .RW(RW), .Q(Q), .Q_OE(Q_OE), .LEGACY_MODE(LEGACY_MODE));

`default_nettype wire
